// >>> dtm_defines.svh
// constants for the delay timer cell
`ifndef DTM_DEFINES_SVH
`define DTM_DEFINES_SVH
`define DTM_CLK_HZ 250000000
`define DTM_TB_LSB 12
`define DTM_TB_MSB 13
`define DTM_CNT_W 10
`define DTM_TB_10MS_NS 10000000
`define DTM_TB_100MS_NS 100000000
`define DTM_TB_1S_MS 1000
`define DTM_TB_10S_MS 10000
// cycles per 10 ms tick at 250 MHz, the smallest base
`define DTM_TICK_10MS_CYC (`DTM_TB_10MS_NS / 4)
`define DTM_PRE_W 32
`endif

// >>> dtm_pkg.sv
// types for the delay timer cell
package dtm_pkg;
    typedef enum logic [1:0] {
        DTM_ON_DELAY = 2'b00,
        DTM_LATCHED_ON_DELAY = 2'b01,
        DTM_OFF_DELAY = 2'b10
    } dtm_mode_t;
    typedef enum logic [1:0] {
        DTM_IDLE = 2'b00,
        DTM_RUN = 2'b01,
        DTM_DONE = 2'b10
    } dtm_state_t;
endpackage

// >>> dtm_sync.sv
// two flip-flop synchroniser for pin inputs
module dtm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;
    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// >>> dtm_prescaler.sv
// time base tick generator: 10 ms, 100 ms, 1 s or 10 s
`include "dtm_defines.svh"
module dtm_prescaler #(
    parameter logic [31:0] TICK_CYC = `DTM_TICK_10MS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [1:0] base,
    output logic tick
);
    logic [31:0] cyc_cnt;
    logic [9:0] dec_cnt;
    logic base_tick;
    logic [9:0] dec_limit;
    // decade count of base ticks for each code
    always_comb begin
        case (base)
            2'b00: dec_limit = 10'H001;
            2'b01: dec_limit = 10'H00A;
            2'b10: dec_limit = 10'H064;
            default: dec_limit = 10'H3E8;
        endcase
    end
    assign base_tick = (cyc_cnt == TICK_CYC - 32'H1);
    // restart aligns the first tick one full interval after load
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            cyc_cnt <= 32'H0;
        end else if (base_tick) begin
            cyc_cnt <= 32'H0;
        end else begin
            cyc_cnt <= cyc_cnt + 32'H1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            dec_cnt <= 10'H0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (base_tick) begin
                if (dec_cnt == dec_limit - 10'H1) begin
                    dec_cnt <= 10'H0;
                    tick <= 1'b1;
                end else begin
                    dec_cnt <= dec_cnt + 10'H1;
                end
            end
        end
    end
endmodule

// >>> dtm_timer.sv
// delay timer cell: on-delay, latched on-delay and off-delay
`include "dtm_defines.svh"
//
// Overview of operation
// - on-delay output rises after expiry, trigger high
// - short trigger gives no output pulse
// - on-delay modes start only on rising trigger
// - falling trigger stops running on-delay timer
// - on-delay counts only while trigger high
// - rising clear zeroes count and time base; in off-delay only while running
// - high clear resets idle on-delay timer
// - on-delay output 1 after clean expiry, trigger high
// - stopped on-delay timer outputs 0
// - idle after clear outputs 0 despite trigger
// - remaining count on binary and tagged outputs
// - latched mode: output rises after expiry regardless
// - latched rising trigger before expiry reloads and restarts countdown
// - latched countdown ignores falling trigger
// - latched rising clear resets regardless of trigger
// - latched output stays 1 until clear
// - off-delay rising trigger sets output immediately
// - off-delay falling trigger starts countdown, then 0
// - off-delay starts on edge, not level
// - every falling trigger restarts off-delay countdown
// - off-delay rising clear resets running timer
// - off-delay output is trigger or running
// - time base in bits 12 and 13
// - base codes select 10ms,100ms,1s,10s
// - decrement one per interval, stop at zero
// - binary remaining count on 16-bit output
module dtm_timer
    import dtm_pkg::*;
#(
    parameter logic [31:0] TICK_CYC = `DTM_TICK_10MS_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [1:0] MODE,
    input wire logic TRIGGER,
    input wire logic CLEAR,
    input wire logic [15:0] PRESET_VALUE,
    output logic TIMER_OUT,
    output logic [15:0] REMAINING_COUNT_BINARY,
    output logic [15:0] TAGGED_TIME_VALUE
);
    logic [1:0] sync_in;
    logic trig;
    logic clr;
    logic trig_prev;
    logic clr_prev;
    logic trig_rise;
    logic trig_fall;
    logic clr_rise;
    logic load;
    logic tick;
    logic [`DTM_CNT_W-1:0] count;
    logic [1:0] base;
    dtm_state_t state;
    dtm_state_t next_state;
    dtm_mode_t mode;
    logic next_out;

    // trigger and clear arrive from pins
    dtm_sync #(.WIDTH(2)) u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .din({CLEAR, TRIGGER}),
        .dout(sync_in)
    );
    assign trig = sync_in[0];
    assign clr = sync_in[1];
    assign mode = dtm_mode_t'(MODE);

    // edges against last cycle's level
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            trig_prev <= 1'b0;
            clr_prev <= 1'b0;
        end else begin
            trig_prev <= trig;
            clr_prev <= clr;
        end
    end
    assign trig_rise = trig && !trig_prev;
    assign trig_fall = !trig && trig_prev;
    assign clr_rise = clr && !clr_prev;

    // clear decoding, per mode
    function automatic logic clear_hit(dtm_mode_t m, logic lvl, logic rise,
                                       dtm_state_t s);
        case (m)
            DTM_ON_DELAY: clear_hit = lvl;
            DTM_LATCHED_ON_DELAY: clear_hit = rise;
            DTM_OFF_DELAY: clear_hit = rise && (s == DTM_RUN);
            default: clear_hit = lvl;
        endcase
    endfunction

    // a load happens on the start edge of the selected mode
    always_comb begin
        case (mode)
            DTM_ON_DELAY: load = trig_rise;
            // an expired latched timer holds its output until a clear
            DTM_LATCHED_ON_DELAY: load = trig_rise && (state != DTM_DONE);
            DTM_OFF_DELAY: load = trig_fall;
            default: load = 1'b0;
        endcase
        if (clear_hit(mode, clr, clr_rise, state)) begin
            load = 1'b0;
        end
    end

    // tick restarts with each load so the first interval is whole
    dtm_prescaler #(.TICK_CYC(TICK_CYC)) u_pre (
        .clk(SYS_CLK),
        .rst(RST),
        .restart(load),
        .base(base),
        .tick(tick)
    );

    // state sequencing
    always_comb begin
        next_state = state;
        if (clear_hit(mode, clr, clr_rise, state)) begin
            next_state = DTM_IDLE;
        end else if (load) begin
            next_state = DTM_RUN;
            if (PRESET_VALUE[`DTM_CNT_W-1:0] == '0) begin
                next_state = DTM_DONE;
            end
        end else begin
            case (state)
                DTM_RUN: begin
                    if (mode == DTM_ON_DELAY && !trig) begin
                        next_state = DTM_IDLE;
                    end else if (tick && count == 10'H001) begin
                        next_state = DTM_DONE;
                    end
                end
                DTM_DONE: begin
                    if (mode == DTM_ON_DELAY && !trig) begin
                        next_state = DTM_IDLE;
                    end
                end
                DTM_IDLE: next_state = DTM_IDLE;
                default: next_state = DTM_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= DTM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // count and time base; clear zeroes both
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            count <= '0;
            base <= 2'b00;
        end else if (clear_hit(mode, clr, clr_rise, state)) begin
            count <= '0;
            base <= 2'b00;
        end else if (load) begin
            count <= PRESET_VALUE[`DTM_CNT_W-1:0];
            base <= PRESET_VALUE[`DTM_TB_MSB:`DTM_TB_LSB];
        end else if (state == DTM_RUN && tick && count != '0) begin
            if (mode != DTM_ON_DELAY || trig) begin
                count <= count - 10'H001;
            end
        end
    end

    // output level per mode
    always_comb begin
        case (mode)
            DTM_ON_DELAY:
                next_out = (next_state == DTM_DONE) && trig;
            DTM_LATCHED_ON_DELAY:
                next_out = (next_state == DTM_DONE);
            DTM_OFF_DELAY:
                next_out = trig || (next_state == DTM_RUN);
            default: next_out = 1'b0;
        endcase
    end

    // registered outputs, count shown in both forms
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            TIMER_OUT <= 1'b0;
        end else begin
            TIMER_OUT <= next_out;
        end
    end
    assign REMAINING_COUNT_BINARY = {6'H00, count};
    assign TAGGED_TIME_VALUE = {2'b00, base, 2'b00, count};
endmodule

// >>> dtm_ctl_model.sv
// controller model driving mode, trigger, clear and preset
module dtm_ctl_model (
    input wire logic clk,
    output logic [1:0] mode,
    output logic trig,
    output logic clr,
    output logic [15:0] preset
);
    initial begin
        mode = 2'h0;
        trig = 1'b0;
        clr = 1'b0;
        preset = 16'h0000;
    end
    // mode and preset move only while the cell is held in reset
    task setup(input logic [1:0] m, input logic [15:0] p);
        @(posedge clk);
        mode <= m;
        preset <= p;
    endtask
    // one edge per call, so every edge lasts a full cycle
    task drive(input logic t, input logic c);
        @(posedge clk);
        trig <= t;
        clr <= c;
    endtask
endmodule

// >>> dtm_timer_assertions.sv
// port checker for the delay timer cell
module dtm_timer_chk
    import dtm_pkg::*;
#(
    parameter logic [31:0] TICK_CYC = 32'h4
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [1:0] MODE,
    input wire logic TRIGGER,
    input wire logic CLEAR,
    input wire logic [15:0] PRESET_VALUE,
    input wire logic TIMER_OUT,
    input wire logic [15:0] REMAINING_COUNT_BINARY,
    input wire logic [15:0] TAGGED_TIME_VALUE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // short aliases; inputs reach the state three samples later
    wire logic [15:0] rem = REMAINING_COUNT_BINARY;
    wire logic [15:0] tag = TAGGED_TIME_VALUE;
    wire logic [15:0] pre = {6'h00, PRESET_VALUE[9:0]};
    wire logic m_on = MODE == DTM_ON_DELAY;
    wire logic m_lat = MODE == DTM_LATCHED_ON_DELAY;
    wire logic m_off = MODE == DTM_OFF_DELAY;
    sequence s_step;
        rem != 16'h0000 && rem == $past(rem) - 16'h0001;
    endsequence
    sequence s_on_edge;
        (m_on || (m_lat && !TIMER_OUT)) && $rose(TRIGGER) && !CLEAR;
    endsequence
    sequence s_off_edge;
        m_off && $fell(TRIGGER) && !CLEAR;
    endsequence
    property p_tagged;
        tag[9:0] == rem[9:0] && rem[15:10] == 6'h00 && tag[11:10] == 2'h0
            && tag[15:14] == 2'h0;
    endproperty
    a_tagged: assert property (p_tagged)
        else $error("count outputs disagree");
    property p_count;
        rem != $past(rem) |->
            rem == $past(rem) - 16'h0001 || rem == 16'h0000 || rem == pre;
    endproperty
    a_count: assert property (p_count)
        else $error("count moved wrongly");
    property p_gap;
        s_step ##0 TICK_CYC > 32'h3 |=> (rem != $past(rem) - 16'h0001)[*3];
    endproperty
    a_gap: assert property (p_gap)
        else $error("ticks too close");
    property p_start;
        s_on_edge |-> ##3 rem == pre;
    endproperty
    a_start: assert property (p_start)
        else $error("no load on rising trigger");
    property p_off_start;
        s_off_edge |-> ##3 rem == pre && tag[13:12] == PRESET_VALUE[13:12];
    endproperty
    a_off_start: assert property (p_off_start)
        else $error("no load on falling trigger");
    property p_off_set;
        m_off && $rose(TRIGGER) && !CLEAR |-> ##3 TIMER_OUT;
    endproperty
    a_off_set: assert property (p_off_set)
        else $error("output not set");
    property p_off_end;
        (m_off && !TRIGGER)[*5] ##0 rem == 16'h0000 |=> !TIMER_OUT;
    endproperty
    a_off_end: assert property (p_off_end)
        else $error("output held after expiry");
    property p_on_rise;
        m_on && $rose(TIMER_OUT) |-> $past(TRIGGER, 3) && rem == 16'h0000;
    endproperty
    a_on_rise: assert property (p_on_rise)
        else $error("output rose early");
    property p_on_low;
        m_on && !$past(TRIGGER, 3) |-> !TIMER_OUT;
    endproperty
    a_on_low: assert property (p_on_low)
        else $error("output high without trigger");
    property p_on_clear;
        m_on && $past(CLEAR, 3) |-> !TIMER_OUT && tag == 16'h0000;
    endproperty
    a_on_clear: assert property (p_on_clear)
        else $error("clear ignored");
    property p_lat_clear;
        m_lat && $rose(CLEAR) |-> ##3 !TIMER_OUT && rem == 16'h0000;
    endproperty
    a_lat_clear: assert property (p_lat_clear)
        else $error("latched clear ignored");
    property p_lat_hold;
        m_lat && $fell(TIMER_OUT) |-> $past(CLEAR, 3);
    endproperty
    a_lat_hold: assert property (p_lat_hold)
        else $error("latched output dropped");
endmodule
bind dtm_timer dtm_timer_chk #(.TICK_CYC(TICK_CYC)) u_chk (
    .SYS_CLK, .RST, .MODE, .TRIGGER, .CLEAR, .PRESET_VALUE, .TIMER_OUT,
    .REMAINING_COUNT_BINARY, .TAGGED_TIME_VALUE
);

// >>> dtm_timer_test.sv
// testbench for the delay timer cell
module dtm_timer_test import dtm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode;
    logic trig;
    logic clr;
    logic out;
    logic [15:0] pre;
    logic [15:0] rem;
    logic [15:0] tag;
    int n_errors = 0;
    int n_compared = 0;
    always #2 clk = ~clk;
    dtm_ctl_model u_dtm_ctl_model (.clk(clk), .mode(mode), .trig(trig),
        .clr(clr), .preset(pre));
    // tick of 4 cycles keeps every interval short
    dtm_timer #(.TICK_CYC(32'h4)) u_dtm_timer (.SYS_CLK(clk), .RST(rst),
        .MODE(mode), .TRIGGER(trig), .CLEAR(clr), .PRESET_VALUE(pre),
        .TIMER_OUT(out), .REMAINING_COUNT_BINARY(rem),
        .TAGGED_TIME_VALUE(tag));
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // sample just after the edge so its updates have landed
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task go(input logic t, input logic c);
        u_dtm_ctl_model.drive(t, c);
    endtask
    // reset for 8 cycles while the mode changes
    task start(input logic [1:0] m, input logic [15:0] p);
        @(posedge clk);
        rst <= 1'b1;
        // pins low before release, so no false edge follows reset
        u_dtm_ctl_model.drive(1'b0, 1'b0);
        u_dtm_ctl_model.setup(m, p);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask
    task t_on;
        start(DTM_ON_DELAY, 16'h0003);
        go(1, 0);
        wt(14);
        chk("rem", 16'h0001, rem);
        chk("out", 16'h0000, 16'(out));
        wt(2);
        chk("out", 16'h0001, 16'(out));
        go(0, 0);
        wt(3);
        chk("out", 16'h0000, 16'(out));
        go(1, 0);
        wt(10);
        go(0, 0);
        wt(8);
        chk("out", 16'h0000, 16'(out));
        go(1, 0);
        wt(5);
        go(1, 1);
        wt(12);
        chk("tag", 16'h0000, tag);
        chk("out", 16'h0000, 16'(out));
        go(1, 0);
        wt(20);
        chk("out", 16'h0000, 16'(out));
    endtask
    task t_lat;
        start(DTM_LATCHED_ON_DELAY, 16'h0002);
        go(1, 0);
        go(0, 0);
        wt(6);
        go(1, 0);
        go(0, 0);
        wt(2);
        chk("rem", 16'h0002, rem);
        wt(28);
        chk("out", 16'h0001, 16'(out));
        go(1, 0);
        go(0, 0);
        wt(4);
        chk("out", 16'h0001, 16'(out));
        go(0, 1);
        wt(3);
        chk("out", 16'h0000, 16'(out));
        go(0, 0);
    endtask
    task t_off;
        start(DTM_OFF_DELAY, 16'h0002);
        go(1, 0);
        wt(3);
        chk("out", 16'h0001, 16'(out));
        go(0, 0);
        wt(3);
        chk("rem", 16'h0002, rem);
        wt(7);
        chk("out", 16'h0001, 16'(out));
        wt(2);
        chk("out", 16'h0000, 16'(out));
        go(1, 0);
        go(0, 0);
        go(0, 1);
        wt(4);
        chk("out", 16'h0000, 16'(out));
        chk("rem", 16'h0000, rem);
        go(0, 0);
    endtask
    // 100 ms base: ten ticks make one interval
    task t_base;
        start(DTM_OFF_DELAY, 16'h1001);
        go(1, 0);
        go(0, 0);
        wt(3);
        chk("tag", 16'h1001, tag);
        wt(40);
        chk("rem", 16'h0001, rem);
        wt(1);
        chk("rem", 16'h0000, rem);
    endtask
    task wrap_up;
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        t_on;
        t_lat;
        t_off;
        t_base;
        wrap_up;
    end
    // the tests need a few hundred cycles; this cuts a hang short
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        wrap_up;
    end
endmodule
